/* rtl/clhp_pkg.sv */
// Shared constants and types for the character display parallel port.
package clhp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned E_PULSE_NS = 150;
  localparam int unsigned E_CYCLE_NS = 400;
  localparam int unsigned ADDR_SETUP_NS = 30;
  localparam int unsigned E_PULSE_CYC = (E_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned E_LOW_CYC = (E_CYCLE_NS - E_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUSY_CYC = 64;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam logic [7:0] FUNC_SET_MASK = 8'he0;
  localparam logic [7:0] FUNC_SET_CODE = 8'h20;
  localparam int unsigned WIDTH_BIT_POS = 4;
  localparam int unsigned BUSY_BIT_POS = 7;
  localparam logic RESET_WIDE = 1'b1;
  typedef enum logic [2:0] {
    CLHP_IDLE = 3'b000,
    CLHP_SETUP = 3'b001,
    CLHP_HIGH = 3'b010,
    CLHP_LOW = 3'b011,
    CLHP_POLL = 3'b100
  } clhp_state_e;
endpackage : clhp_pkg

/* rtl/clhp_bus_if.sv */
// Pin-level carrier between the host end and the display controller end.
`timescale 1ns/1ps
`default_nettype none
interface clhp_bus_if;
  logic register_select;
  logic read_not_write;
  logic enable;
  logic [7:0] host_data;
  logic [7:0] host_data_oe;
  logic [7:0] dev_data;
  logic [7:0] dev_data_oe;
  logic [7:0] bidir_bus_lines;
  genvar gi;
  for (gi = 0; gi < 8; gi++) begin : g_res
    assign bidir_bus_lines[gi] = host_data_oe[gi] ? host_data[gi] : (dev_data_oe[gi] ? dev_data[gi] : 1'b1);
  end
  modport host (output register_select, output read_not_write, output enable, output host_data,
                output host_data_oe, input bidir_bus_lines);
  modport dev (input register_select, input read_not_write, input enable, output dev_data,
               output dev_data_oe, input bidir_bus_lines);
endinterface : clhp_bus_if
`default_nettype wire

/* rtl/clhp_fifo.sv */
// Parameterised valid/ready FIFO for the host's outgoing transfers.
`timescale 1ns/1ps
`default_nettype none
module clhp_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out = mem[rd_ptr_r];
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : clhp_fifo
`default_nettype wire

/* rtl/clhp_host.sv */
// Host end: queues byte requests and runs them as strobed bus cycles.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Select high addresses display data register.
// - Select low: instruction write, status read.
// - Direction high reads, low writes, set first.
// - Every transfer is one enable strobe in wide mode, two in narrow mode.
// - Eight bidirectional lines, writer drives them.
// - Narrow mode uses upper four lines only.
// - Narrow mode: high nibble then low nibble.
// - Wide mode moves a byte at once.
// - Width bit in configuration selects width.
// - Status: busy on bit 7, pointer below.
module clhp_host #(
  parameter int unsigned DEPTH = clhp_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  clhp_bus_if.host bus,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic req_rs_in,
  input wire logic req_read_in,
  input wire logic [7:0] req_data_in,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic wide_mode_out
);
  logic [9:0] q_data;
  logic q_valid;
  logic q_ready;
  logic fifo_ready;
  logic req_take;
  clhp_fifo #(.WIDTH(10), .DEPTH(DEPTH)) clhp_fifo_i (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(req_take),
    .in_ready_out(fifo_ready),
    .in_data_in({req_read_in, req_rs_in, req_data_in}),
    .out_valid_out(q_valid),
    .out_ready_in(q_ready),
    .out_data_out(q_data)
  );
  clhp_pkg::clhp_state_e state_r;
  clhp_pkg::clhp_state_e state_nxt;
  logic [7:0] cnt_r;
  logic second_r;
  logic polling_r;
  logic wide_r;
  logic rs_r;
  logic rd_r;
  logic en_r;
  logic [7:0] byte_r;
  logic [7:0] rx_r;
  logic rsp_valid_r;
  logic req_ready_r;
  logic [7:0] drv_r;
  logic [7:0] oe_r;
  wire cnt_done = (cnt_r == 8'h00);
  wire last_phase = wide_r || second_r;
  // A request is only taken against the registered ready, so the port never promises room the queue lacks.
  assign req_take = req_valid_in && req_ready_r;
  wire phase_end = (state_r == clhp_pkg::CLHP_LOW) && cnt_done;
  wire byte_end = phase_end && last_phase;
  wire user_end = byte_end && !polling_r;
  wire width_write = !rd_r && !rs_r && ((byte_r & clhp_pkg::FUNC_SET_MASK) == clhp_pkg::FUNC_SET_CODE);
  wire busy_seen = rx_r[clhp_pkg::BUSY_BIT_POS];
  // Narrow mode reads arrive on the upper lines; first strobe is the high nibble.
  wire [7:0] rx_nxt = wide_r ? bus.bidir_bus_lines : (second_r ? {rx_r[7:4], bus.bidir_bus_lines[7:4]}
                                                                : {bus.bidir_bus_lines[7:4], 4'h0});
  wire [7:0] tx_nibble = second_r ? {byte_r[3:0], 4'h0} : {byte_r[7:4], 4'h0};
  wire [7:0] tx_word = wide_r ? byte_r : tx_nibble;
  assign q_ready = (state_r == clhp_pkg::CLHP_IDLE) && !polling_r;
  assign req_ready_out = req_ready_r;
  assign rsp_valid_out = rsp_valid_r;
  assign rsp_data_out = rx_r;
  assign wide_mode_out = wide_r;
  assign bus.register_select = rs_r;
  assign bus.read_not_write = rd_r;
  assign bus.enable = en_r;
  assign bus.host_data = drv_r;
  assign bus.host_data_oe = oe_r;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      clhp_pkg::CLHP_IDLE: begin
        if (polling_r || q_valid) begin
          state_nxt = clhp_pkg::CLHP_SETUP;
        end
      end
      clhp_pkg::CLHP_SETUP: if (cnt_done) state_nxt = clhp_pkg::CLHP_HIGH;
      clhp_pkg::CLHP_HIGH: if (cnt_done) state_nxt = clhp_pkg::CLHP_LOW;
      clhp_pkg::CLHP_LOW: begin
        if (cnt_done) begin
          state_nxt = last_phase ? clhp_pkg::CLHP_IDLE : clhp_pkg::CLHP_SETUP;
        end
      end
      default: state_nxt = clhp_pkg::CLHP_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_r <= clhp_pkg::CLHP_IDLE;
      cnt_r <= 8'h00;
      rs_r <= 1'b0;
      rd_r <= 1'b1;
      en_r <= 1'b0;
      byte_r <= 8'h00;
      rx_r <= 8'h00;
      drv_r <= 8'h00;
      oe_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_done ? 8'h00 : cnt_r - 8'h01;
      case (state_r)
        clhp_pkg::CLHP_IDLE: begin
          if (polling_r) begin
            rs_r <= 1'b0;
            rd_r <= 1'b1;
            cnt_r <= 8'(clhp_pkg::SETUP_CYC);
          end else if (q_valid) begin
            rs_r <= q_data[8];
            rd_r <= q_data[9];
            byte_r <= q_data[7:0];
            cnt_r <= 8'(clhp_pkg::SETUP_CYC);
          end
        end
        clhp_pkg::CLHP_SETUP: begin
          if (!rd_r) begin
            drv_r <= tx_word;
            oe_r <= wide_r ? 8'hff : 8'hf0;
          end
          if (cnt_done) begin
            en_r <= 1'b1;
            cnt_r <= 8'(clhp_pkg::E_PULSE_CYC);
          end
        end
        clhp_pkg::CLHP_HIGH: begin
          if (cnt_done) begin
            en_r <= 1'b0;
            cnt_r <= 8'(clhp_pkg::E_LOW_CYC);
            if (rd_r) begin
              rx_r <= rx_nxt;
            end
          end
        end
        clhp_pkg::CLHP_LOW: begin
          if (cnt_done) begin
            oe_r <= 8'h00;
            if (!last_phase) begin
              cnt_r <= 8'(clhp_pkg::SETUP_CYC);
            end else begin
              // Direction returns to read so an idle bus never has the host driving it.
              rd_r <= 1'b1;
            end
          end
        end
        default: en_r <= 1'b0;
      endcase
    end
  end
  // Ready drops for a cycle after each take, which keeps a nearly full queue from being overrun.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      req_ready_r <= 1'b0;
    end else begin
      req_ready_r <= fifo_ready && !req_take;
    end
  end
  // Only reads asked for by the user answer; the host's own status polls stay internal.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_valid_r <= user_end && rd_r;
    end
  end
  // Width follows a configuration write only once its last strobe is over, as on the far end.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      wide_r <= clhp_pkg::RESET_WIDE;
    end else if (user_end && width_write) begin
      wide_r <= byte_r[clhp_pkg::WIDTH_BIT_POS];
    end
  end
  // Every write is followed by status polls until busy clears.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      polling_r <= 1'b0;
    end else if (byte_end) begin
      polling_r <= polling_r ? busy_seen : !rd_r;
    end
  end
  // Narrow mode: the first strobe of a byte carries the high nibble, the second the low one.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      second_r <= 1'b0;
    end else if (state_r == clhp_pkg::CLHP_IDLE) begin
      second_r <= 1'b0;
    end else if (phase_end && !last_phase) begin
      second_r <= 1'b1;
    end
  end
endmodule : clhp_host
`default_nettype wire

/* rtl/clhp_dev.sv */
// Display controller end: decodes strobed cycles into instruction, data and status accesses.
`timescale 1ns/1ps
`default_nettype none
module clhp_dev #(
  parameter int unsigned BUSY_CYCLES = clhp_pkg::BUSY_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  clhp_bus_if.dev bus,
  output logic instr_valid_out,
  output logic [7:0] instr_out,
  output logic data_valid_out,
  output logic [7:0] data_out,
  input wire logic [7:0] read_data_in,
  output logic data_read_out,
  output logic wide_mode_out
);
  logic en_d_r;
  logic wide_r;
  logic second_r;
  logic [3:0] hi_r;
  logic [6:0] ptr_r;
  logic [15:0] busy_cnt_r;
  logic [7:0] iv_r;
  logic ivl_r;
  logic dvl_r;
  logic drd_r;
  logic [7:0] dv_r;
  wire busy = (busy_cnt_r != 16'h0000);
  wire fall = en_d_r && !bus.enable;
  wire rd_drive = bus.enable && bus.read_not_write;
  wire [7:0] status = {busy, ptr_r};
  wire [7:0] rd_byte = bus.register_select ? read_data_in : status;
  wire [7:0] rd_lane = wide_r ? rd_byte : (second_r ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0});
  // Lower lines are ignored in narrow mode.
  wire [7:0] wr_byte = wide_r ? bus.bidir_bus_lines : {hi_r, bus.bidir_bus_lines[7:4]};
  wire complete = fall && (wide_r || second_r);
  wire wr_done = complete && !bus.read_not_write;
  wire is_fs = !bus.register_select && ((wr_byte & clhp_pkg::FUNC_SET_MASK) == clhp_pkg::FUNC_SET_CODE);
  assign bus.dev_data = rd_lane;
  assign bus.dev_data_oe = rd_drive ? (wide_r ? 8'hff : 8'hf0) : 8'h00;
  assign instr_valid_out = ivl_r;
  assign instr_out = iv_r;
  assign data_valid_out = dvl_r;
  assign data_out = dv_r;
  assign data_read_out = drd_r;
  assign wide_mode_out = wide_r;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      en_d_r <= 1'b0;
      wide_r <= clhp_pkg::RESET_WIDE;
      second_r <= 1'b0;
      hi_r <= 4'h0;
      ptr_r <= 7'h00;
      busy_cnt_r <= 16'h0000;
      iv_r <= 8'h00;
      ivl_r <= 1'b0;
      dvl_r <= 1'b0;
      drd_r <= 1'b0;
      dv_r <= 8'h00;
    end else begin
      en_d_r <= bus.enable;
      ivl_r <= 1'b0;
      dvl_r <= 1'b0;
      drd_r <= 1'b0;
      if (busy) begin
        busy_cnt_r <= busy_cnt_r - 16'h0001;
      end
      if (fall && !wide_r) begin
        second_r <= !second_r;
        hi_r <= bus.bidir_bus_lines[7:4];
      end
      if (wr_done) begin
        busy_cnt_r <= 16'(BUSY_CYCLES);
        if (bus.register_select) begin
          dv_r <= wr_byte;
          dvl_r <= 1'b1;
          ptr_r <= ptr_r + 7'h01;
        end else begin
          iv_r <= wr_byte;
          ivl_r <= 1'b1;
          if (wr_byte[7]) begin
            ptr_r <= wr_byte[6:0];
          end
          if (is_fs) begin
            wide_r <= wr_byte[clhp_pkg::WIDTH_BIT_POS];
            second_r <= 1'b0;
          end
        end
      end
      if (complete && bus.read_not_write && bus.register_select) begin
        drd_r <= 1'b1;
        ptr_r <= ptr_r + 7'h01;
      end
    end
  end
endmodule : clhp_dev
`default_nettype wire

/* verif/clhp_properties.sv */
// Timing and drive checks on the bus carrier between the two ends.
`timescale 1ns/1ps
`default_nettype none
module clhp_properties (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic register_select,
  input wire logic read_not_write,
  input wire logic enable,
  input wire logic [7:0] host_data_oe,
  input wire logic [7:0] dev_data_oe,
  input wire logic [7:0] bidir_bus_lines
);
  localparam int PULSE_MAX = 40;
  logic [7:0] hi_r;
  logic [7:0] lo_r;
  // The low counter saturates so a long idle never wraps into a false short gap.
  always_ff @(posedge ref_clk_in) begin
    hi_r <= (!rst_n_in || !enable) ? 8'h00 : hi_r + 8'h01;
    lo_r <= !rst_n_in ? 8'hff : (enable ? 8'h00 : (lo_r == 8'hff ? lo_r : lo_r + 8'h01));
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_NO_CLASH: assert property (!(|host_data_oe && |dev_data_oe))
    else $error("both ends drive the bus");
  AST_DEV_ONLY_READ: assert property (|dev_data_oe |-> enable && read_not_write)
    else $error("device drives outside a read strobe");
  AST_DEV_ANSWERS: assert property (enable && read_not_write |-> dev_data_oe[7:4] == 4'hf)
    else $error("device silent during read");
  AST_HOST_OFF_READ: assert property (enable && read_not_write |-> host_data_oe == 8'h00)
    else $error("host drives during read");
  AST_CTRL_HELD: assert property (enable |-> $stable(register_select) && $stable(read_not_write))
    else $error("select or direction moved in strobe");
  AST_PULSE_MIN: assert property ($fell(enable) |-> hi_r >= clhp_pkg::E_PULSE_CYC)
    else $error("enable pulse too short");
  AST_CYCLE_MIN: assert property ($rose(enable) |-> lo_r >= clhp_pkg::E_LOW_CYC)
    else $error("enable low gap too short");
  AST_WR_DATA: assert property (enable && !read_not_write |-> &host_data_oe[7:4] && $stable(bidir_bus_lines[7:4]))
    else $error("write data not steady in strobe");
  AST_PULSE_END: assert property ($rose(enable) |-> ##[1:PULSE_MAX] !enable)
    else $error("enable stuck high");
  cover property ($rose(enable) && !read_not_write && register_select);
  cover property ($rose(enable) && read_not_write && !register_select);
  cover property ($rose(enable) && read_not_write && register_select);
endmodule : clhp_properties
`default_nettype wire

/* verif/char_lcd_host_parallel_port_tb.sv */
// Bench joining the host end and the display end across the bus carrier.
`timescale 1ns/1ps
`default_nettype none
module char_lcd_host_parallel_port_tb;
  logic ref_clk_in, rst_n_in, req_valid, req_ready, req_rs, req_read, rsp_valid, iv, dv, dr, hw, dw, saw_full;
  logic [7:0] req_data, rsp_data, ins, dat, rd_data;
  logic [7:0] iq[$], dq[$], rq[$];
  logic [6:0] ptr;
  int n_errors = 0;
  int n_checks = 0;
  clhp_bus_if clhp_bus_if_i ();
  clhp_host clhp_host_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus(clhp_bus_if_i.host),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .req_rs_in(req_rs), .req_read_in(req_read),
    .req_data_in(req_data), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .wide_mode_out(hw));
  // Busy time is shortened so the first status poll after each write already finds busy clear.
  clhp_dev #(.BUSY_CYCLES(4)) clhp_dev_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus(clhp_bus_if_i.dev),
    .instr_valid_out(iv), .instr_out(ins), .data_valid_out(dv), .data_out(dat), .read_data_in(rd_data),
    .data_read_out(dr), .wide_mode_out(dw));
  clhp_properties clhp_properties_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .register_select(clhp_bus_if_i.register_select), .read_not_write(clhp_bus_if_i.read_not_write),
    .enable(clhp_bus_if_i.enable), .host_data_oe(clhp_bus_if_i.host_data_oe),
    .dev_data_oe(clhp_bus_if_i.dev_data_oe), .bidir_bus_lines(clhp_bus_if_i.bidir_bus_lines));
  task automatic check(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  // Expectations are noted at acceptance, so queue order equals bus order.
  task automatic send(logic rs, logic rd, logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    req_rs = rs;
    req_read = rd;
    req_data = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) begin
      saw_full = 1'b1;
      @(posedge ref_clk_in);
      #1;
    end
    @(posedge ref_clk_in);
    #1;
    req_valid = 1'b0;
    if (rd)
      rq.push_back(rs ? rd_data : {1'b0, ptr});
    else if (rs)
      dq.push_back(d);
    else
      iq.push_back(d);
    if (rs)
      ptr++;
    else if (!rd && d[7])
      ptr = d[6:0];
  endtask : send
  task automatic drain();
    int k;
    k = 0;
    while (iq.size() + dq.size() + rq.size() > 0 && k < 20000) begin
      @(posedge ref_clk_in);
      k++;
    end
    if (k >= 20000)
      n_errors++;
  endtask : drain
  task automatic phase();
    send(1'b0, 1'b0, 8'h85);
    repeat (6) send(1'b1, 1'b0, 8'($urandom));
    send(1'b0, 1'b1, 8'h00);
    drain();
    rd_data = 8'($urandom);
    send(1'b1, 1'b1, 8'h00);
    drain();
  endtask : phase
  task automatic set_width(logic w);
    send(1'b0, 1'b0, {3'b001, w, 4'h0});
    send(1'b0, 1'b1, 8'h00);
    drain();
    check("host width", {7'h00, w}, {7'h00, hw});
    check("dev width", {7'h00, w}, {7'h00, dw});
  endtask : set_width
  always @(negedge ref_clk_in) begin
    if (rst_n_in === 1'b1 && iv === 1'b1) check("instr", iq.pop_front(), ins);
    if (rst_n_in === 1'b1 && dv === 1'b1) check("data", dq.pop_front(), dat);
    if (rst_n_in === 1'b1 && rsp_valid === 1'b1) check("read", rq.pop_front(), rsp_data);
  end
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    #800000;
    n_errors++;
    close_out();
  end
  initial begin
    rst_n_in = 1'b0;
    {req_valid, req_rs, req_read, saw_full} = 4'h0;
    req_data = 8'h00;
    rd_data = 8'h00;
    ptr = 7'h00;
    void'($urandom(32'h506d));
    repeat (2) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    check("reset width", 8'h01, {6'h00, hw, dw} >> 1 & {7'h00, dw});
    phase();
    set_width(1'b0);
    phase();
    set_width(1'b1);
    saw_full = 1'b0;
    repeat (40) send(1'b1, 1'b0, 8'($urandom));
    drain();
    check("fifo refused", 8'h01, {7'h00, saw_full});
    check("pending", 8'h00, 8'(iq.size() + dq.size() + rq.size()));
    close_out();
  end
endmodule : char_lcd_host_parallel_port_tb
`default_nettype wire
